// *** rtl/stop_ctrl_map.svh ***
// Offsets, field positions, reset values and timing counts of the stop controller.
// Assumes inclusion by bare name from design and testbench files.
`ifndef STOP_CTRL_MAP_SVH
`define STOP_CTRL_MAP_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SPC_CTRL_OFS 8'h00
`define SPC_PERIPH_OFS 8'h04
`define SPC_STATUS_OFS 8'h08
`define SPC_ACK_OFS 8'h0C
// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define SPC_STOP_EN_BIT 0
`define SPC_PPD_SEL_BIT 1
`define SPC_LVD_EN_BIT 2
`define SPC_LVD_STOP_EN_BIT 3
`define SPC_DBG_EN_BIT 4
`define SPC_CTRL_RESET 32'h0000000C
`define SPC_CTRL_MASK 32'h0000001F
// ----------------------------------------------------------------
// Peripheral stop option fields
// ----------------------------------------------------------------
`define SPC_ADC_ASYNC_BIT 0
`define SPC_CMP_BANDGAP_BIT 1
`define SPC_IREF_CLK_BIT 2
`define SPC_IREF_STOP_BIT 3
`define SPC_EREF_CLK_BIT 4
`define SPC_EREF_STOP_BIT 5
`define SPC_CRYSTAL_OSCILLATOR_HIGH_BIT 6
`define SPC_USB_EN_BIT 7
`define SPC_USB_PHY_BIT 8
`define SPC_RTC_PS_LSB 12
`define SPC_RTC_PS_MSB 15
`define SPC_PERIPH_RESET 32'h00000000
`define SPC_PERIPH_MASK 32'h0000F1FF
// ----------------------------------------------------------------
// Status and acknowledge fields
// ----------------------------------------------------------------
`define SPC_PPD_FLAG_BIT 3
`define SPC_LATCH_BIT 4
`define SPC_LOW_TRIP_BIT 5
`define SPC_ACK_BIT 0
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SPC_POR_HOLD_CYCLES 3'd4
`endif

// *** rtl/stop_ctrl_pkg.sv ***
// Types shared by the stop controller and its testbench.
// Assumes nothing beyond a SystemVerilog compiler.
package stop_ctrl_pkg;
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_STOP3 = 3'b001,
    ST_BDM = 3'b011,
    ST_STOP2 = 3'b100,
    ST_POR = 3'b110
  } power_state_t;

  typedef enum logic [2:0] {
    CMD_BACKGROUND = 3'h0,
    CMD_MEM_STATUS = 3'h1,
    CMD_NONINTRUSIVE = 3'h2,
    CMD_ACTIVE_BG = 3'h3,
    CMD_GO = 3'h4
  } dbg_cmd_t;
endpackage

// *** rtl/stop_wake_if.sv ***
// Carrier between the stop controller and its wake detector.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
interface stop_wake_if #(parameter int IRQ_COUNT = 8);
  logic in_stop2;
  logic in_stop3;
  logic reset_pin_n;
  logic ext_wake_n;
  logic rtc_irq;
  logic [IRQ_COUNT-1:0] irq_src;
  logic wake;
  logic wake_by_pin;
  modport ctrl (output in_stop2, in_stop3, reset_pin_n, ext_wake_n, rtc_irq, irq_src,
    input wake, wake_by_pin);
  modport det (input in_stop2, in_stop3, reset_pin_n, ext_wake_n, rtc_irq, irq_src,
    output wake, wake_by_pin);
endinterface // stop_wake_if

// *** rtl/stop_wake_detect.sv ***
// Wake source decode for both stop flavours.
// Assumes sources are already synchronous to pclk and rtc_irq is pre-gated by its enable.
`timescale 1ns/1ps
module stop_wake_detect (
  stop_wake_if.det w
);
  always_comb begin
    w.wake_by_pin = (w.in_stop2 | w.in_stop3) & ~w.reset_pin_n;
    w.wake = w.wake_by_pin;
    if (w.in_stop2) begin
      // External pin is a low-level wake here whatever it was set up as
      w.wake = w.wake_by_pin | ~w.ext_wake_n | w.rtc_irq;
    end else if (w.in_stop3) begin
      w.wake = w.wake_by_pin | w.rtc_irq | (|w.irq_src);
    end
  end
endmodule // stop_wake_detect

// *** rtl/stop_mode_power_control.sv ***
// Stop entry, residency and wake sequencing with an APB register file.
// Assumes synchronous inputs, a CPU that pulses stop_exec, and an APB master.
`timescale 1ns/1ps
`include "stop_ctrl_map.svh"
module stop_mode_power_control
  import stop_ctrl_pkg::*;
#(
  parameter int PIN_COUNT = 8,
  parameter int IRQ_COUNT = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stop_exec,
  input wire logic reset_pin_n,
  input wire logic external_wake_pin,
  input wire logic rtc_irq,
  input wire logic [IRQ_COUNT-1:0] wake_irq,
  input wire logic dbg_cmd_valid,
  input wire logic [2:0] dbg_cmd_code,
  output logic dbg_cmd_accept,
  output logic dbg_stop_error,
  input wire logic [PIN_COUNT-1:0] port_pin_ctrl,
  input wire logic [PIN_COUNT-1:0] periph_pin_ctrl,
  input wire logic [PIN_COUNT-1:0] periph_pin_en,
  output logic [PIN_COUNT-1:0] pin_ctrl_out,
  output logic illegal_opcode_reset,
  output logic system_reset,
  output logic fetch_reset_vector,
  output logic lvd_reset_enable,
  output logic lvd_low_trip,
  output logic active_background,
  output logic in_stop,
  output logic debug_clk_en,
  output logic regulator_full,
  output logic periph_clk_en,
  output logic core_power_off,
  output logic ram_standby,
  output logic rtc_on,
  output logic adc_on,
  output logic comparator_on,
  output logic internal_ref_on,
  output logic crystal_oscillator_on,
  output logic usb_on
);
  if (PIN_COUNT < 1 || IRQ_COUNT < 1) begin : g_param_check
    $error("stop_mode_power_control: PIN_COUNT and IRQ_COUNT must be at least 1");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  power_state_t state;
  power_state_t next_state;
  logic [31:0] ctrl;
  logic [31:0] periph;
  logic [31:0] ent_periph;
  logic ent_dbg;
  logic ent_lvd;
  logic partial_powerdown_flag;
  logic pin_latch_hold;
  logic [2:0] por_count;
  logic por_from_deep;
  logic illegal_pulse;

  stop_wake_if #(.IRQ_COUNT(IRQ_COUNT)) wk();

  stop_wake_detect u_wake (
    .w(wk)
  );

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic wr_en;
  logic ack_wr;
  logic mapped;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `SPC_CTRL_OFS) || (a == `SPC_PERIPH_OFS) ||
      (a == `SPC_STATUS_OFS) || (a == `SPC_ACK_OFS);
  endfunction

  assign mapped = is_mapped(paddr);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign wr_en = psel & penable & pwrite & mapped;
  assign ack_wr = wr_en && (paddr == `SPC_ACK_OFS) && pwdata[`SPC_ACK_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `SPC_CTRL_OFS: prdata <= ctrl;
        `SPC_PERIPH_OFS: prdata <= periph;
        `SPC_STATUS_OFS: prdata <= {26'h0, lvd_low_trip, pin_latch_hold,
          partial_powerdown_flag, state};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // Power-on style wake from deep stop wipes configuration like a real POR would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `SPC_CTRL_RESET;
      periph <= `SPC_PERIPH_RESET;
    end else if (state == ST_POR && por_from_deep) begin
      ctrl <= `SPC_CTRL_RESET;
      periph <= `SPC_PERIPH_RESET;
    end else if (wr_en && paddr == `SPC_CTRL_OFS) begin
      ctrl <= pwdata & `SPC_CTRL_MASK;
    end else if (wr_en && paddr == `SPC_PERIPH_OFS) begin
      periph <= pwdata & `SPC_PERIPH_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Stop selection
  // ----------------------------------------------------------------
  logic stop_en;
  logic want_deep;
  assign stop_en = ctrl[`SPC_STOP_EN_BIT];
  // Deep stop only without debug and without the detector armed for stop
  assign want_deep = ctrl[`SPC_PPD_SEL_BIT] & ~ctrl[`SPC_DBG_EN_BIT] &
    ~(ctrl[`SPC_LVD_EN_BIT] & ctrl[`SPC_LVD_STOP_EN_BIT]);

  assign wk.in_stop2 = (state == ST_STOP2);
  assign wk.in_stop3 = (state == ST_STOP3);
  assign wk.reset_pin_n = reset_pin_n;
  assign wk.ext_wake_n = external_wake_pin;
  assign wk.rtc_irq = rtc_irq & rtc_on;
  assign wk.irq_src = wake_irq;

  logic bgnd_wake;
  assign bgnd_wake = dbg_cmd_valid && dbg_cmd_code == CMD_BACKGROUND && ent_dbg;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (stop_exec && stop_en) begin
          next_state = want_deep ? ST_STOP2 : ST_STOP3;
        end else if (dbg_cmd_valid && dbg_cmd_code == CMD_BACKGROUND &&
            ctrl[`SPC_DBG_EN_BIT]) begin
          next_state = ST_BDM;
        end
      end
      ST_STOP3: begin
        if (wk.wake_by_pin) begin
          next_state = ST_POR;
        end else if (bgnd_wake) begin
          next_state = ST_BDM;
        end else if (wk.wake) begin
          next_state = ST_RUN;
        end
      end
      ST_STOP2: begin
        if (wk.wake) begin
          next_state = ST_POR;
        end
      end
      ST_POR: begin
        if (por_count == `SPC_POR_HOLD_CYCLES - 3'd1) begin
          next_state = ST_RUN;
        end
      end
      ST_BDM: begin
        if (dbg_cmd_valid && dbg_cmd_code == CMD_GO) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // STOP with stop disabled is an illegal opcode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      illegal_pulse <= 1'b0;
    end else begin
      illegal_pulse <= (state == ST_RUN) && stop_exec && !stop_en;
    end
  end
  assign illegal_opcode_reset = illegal_pulse;

  // Configuration is frozen at entry so mid-stop writes cannot shift power
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ent_dbg <= 1'b0;
      ent_lvd <= 1'b0;
      ent_periph <= 32'h00000000;
    end else if (state == ST_RUN && stop_exec && stop_en) begin
      ent_dbg <= ctrl[`SPC_DBG_EN_BIT];
      ent_lvd <= ctrl[`SPC_LVD_EN_BIT] & ctrl[`SPC_LVD_STOP_EN_BIT];
      ent_periph <= periph;
    end
  end

  // ----------------------------------------------------------------
  // Power-on style recovery
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_count <= 3'd0;
    end else if (state == ST_POR) begin
      por_count <= por_count + 3'd1;
    end else begin
      por_count <= 3'd0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_from_deep <= 1'b0;
    end else if (state != ST_POR) begin
      por_from_deep <= (state == ST_STOP2);
    end
  end

  // Set wins over acknowledge in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      partial_powerdown_flag <= 1'b0;
    end else if (state == ST_STOP2 && wk.wake) begin
      partial_powerdown_flag <= 1'b1;
    end else if (ack_wr) begin
      partial_powerdown_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_latch_hold <= 1'b0;
    end else if (next_state == ST_STOP2 && state == ST_RUN) begin
      pin_latch_hold <= 1'b1;
    end else if (ack_wr && state != ST_STOP2) begin
      pin_latch_hold <= 1'b0;
    end
  end

  // Software must restore ports before the acknowledge or pins snap to reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_ctrl_out <= '0;
    end else if (!pin_latch_hold && !(state == ST_RUN && next_state == ST_STOP2)) begin
      pin_ctrl_out <= (periph_pin_en & periph_pin_ctrl) | (~periph_pin_en & port_pin_ctrl);
    end
  end

  // ----------------------------------------------------------------
  // Debug command gating
  // ----------------------------------------------------------------
  logic stopped;
  assign stopped = (state == ST_STOP2) || (state == ST_STOP3);
  always_comb begin
    dbg_cmd_accept = 1'b0;
    dbg_stop_error = 1'b0;
    if (dbg_cmd_valid) begin
      if (stopped) begin
        dbg_stop_error = (dbg_cmd_code == CMD_MEM_STATUS);
        dbg_cmd_accept = (dbg_cmd_code == CMD_BACKGROUND) && bgnd_wake;
      end else if (state == ST_BDM) begin
        dbg_cmd_accept = 1'b1;
      end else if (state == ST_RUN) begin
        dbg_cmd_accept = (dbg_cmd_code != CMD_ACTIVE_BG) && (dbg_cmd_code != CMD_GO);
      end
    end
  end

  // ----------------------------------------------------------------
  // Power and clock outputs
  // ----------------------------------------------------------------
  logic s3;
  assign s3 = (state == ST_STOP3);
  assign in_stop = stopped;
  assign active_background = (state == ST_BDM);
  assign system_reset = (state == ST_POR);
  assign fetch_reset_vector = (state == ST_POR) &&
    (por_count == `SPC_POR_HOLD_CYCLES - 3'd1);
  assign lvd_reset_enable = por_from_deep | ctrl[`SPC_LVD_EN_BIT];
  assign lvd_low_trip = por_from_deep | partial_powerdown_flag;
  assign periph_clk_en = !stopped;
  assign debug_clk_en = !stopped || (s3 && ent_dbg);
  assign regulator_full = !stopped || (s3 && (ent_dbg || ent_lvd));
  assign core_power_off = (state == ST_STOP2);
  assign ram_standby = stopped;
  assign rtc_on = !stopped || (ent_periph[`SPC_RTC_PS_MSB:`SPC_RTC_PS_LSB] != 4'h0);
  assign adc_on = !stopped || (s3 && ent_periph[`SPC_ADC_ASYNC_BIT] && ent_lvd);
  assign comparator_on = !stopped ||
    (s3 && (!ent_periph[`SPC_CMP_BANDGAP_BIT] || ent_lvd));
  assign internal_ref_on = !stopped ||
    (s3 && ent_periph[`SPC_IREF_CLK_BIT] && ent_periph[`SPC_IREF_STOP_BIT]);
  assign crystal_oscillator_on = !stopped ||
    (s3 && ent_periph[`SPC_EREF_CLK_BIT] && ent_periph[`SPC_EREF_STOP_BIT] &&
    (!ent_periph[`SPC_CRYSTAL_OSCILLATOR_HIGH_BIT] || ent_lvd));
  assign usb_on = !stopped ||
    (s3 && ent_periph[`SPC_USB_EN_BIT] && ent_periph[`SPC_USB_PHY_BIT]);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_ILLEGAL_STOP: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_RUN && stop_exec && !stop_en) |=> illegal_opcode_reset && state == ST_RUN)
    else $error("stop without enable did not raise illegal opcode reset");
  AST_DEBUG_FORCES_STOP3: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_RUN && stop_exec && stop_en && ctrl[`SPC_DBG_EN_BIT])
    |=> state == ST_STOP3 && debug_clk_en && regulator_full)
    else $error("debug enabled stop did not keep debug clocks and regulator");
  AST_LVD_FORCES_STOP3: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_RUN && stop_exec && stop_en && ctrl[`SPC_LVD_EN_BIT] &&
    ctrl[`SPC_LVD_STOP_EN_BIT]) |=> state == ST_STOP3 && regulator_full)
    else $error("detector armed stop did not enter retentive stop");
  AST_PERIPH_CLK_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_RUN && stop_exec && stop_en) |=> in_stop && !periph_clk_en)
    else $error("peripheral clocks running in stop");
  AST_MEM_STATUS_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    (in_stop && dbg_cmd_valid && dbg_cmd_code == CMD_MEM_STATUS)
    |-> dbg_stop_error && !dbg_cmd_accept)
    else $error("memory status command in stop not refused");
  AST_BGND_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_STOP3 && reset_pin_n && ent_dbg && dbg_cmd_valid &&
    dbg_cmd_code == CMD_BACKGROUND) |=> active_background)
    else $error("background command did not wake into background mode");
  AST_DEEP_WAKE_PIN: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_STOP2 && !external_wake_pin) |=> system_reset && partial_powerdown_flag)
    else $error("low wake pin did not leave deep stop as power-on");
  AST_POR_LENGTH: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(system_reset) |-> system_reset [*4] ##1 !system_reset)
    else $error("power-on recovery not four cycles long");
  AST_LATCH_STABLE: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_latch_hold && $past(pin_latch_hold)) |-> $stable(pin_ctrl_out))
    else $error("latched pins changed before acknowledge");
  AST_RTC_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    (in_stop && ent_periph[`SPC_RTC_PS_MSB:`SPC_RTC_PS_LSB] == 4'h0) |-> !rtc_on)
    else $error("timer running in stop with zero prescale");
  AST_FLAG_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (partial_powerdown_flag && !ack_wr) |=> partial_powerdown_flag)
    else $error("powerdown flag cleared without acknowledge");

  COV_DEEP_ROUND: cover property (@(posedge pclk) disable iff (!presetn)
    state == ST_STOP2 ##1 state == ST_POR ##[4:8] state == ST_RUN);
  COV_STOP3_IRQ: cover property (@(posedge pclk) disable iff (!presetn)
    state == ST_STOP3 ##1 state == ST_RUN);
  COV_BDM_FROM_STOP: cover property (@(posedge pclk) disable iff (!presetn)
    state == ST_STOP3 ##1 state == ST_BDM);
  COV_ACK: cover property (@(posedge pclk) disable iff (!presetn)
    pin_latch_hold ##1 !pin_latch_hold);
endmodule // stop_mode_power_control

// *** testbench/debug_host_model.sv ***
// Debug host and wake pin driver on the far side of the stop controller.
// Assumes commands and pins are sampled on the rising edge of pclk.
`timescale 1ns/1ps
module debug_host_model (
  input wire logic pclk,
  input wire logic dbg_cmd_accept,
  input wire logic dbg_stop_error,
  output logic dbg_cmd_valid,
  output logic [2:0] dbg_cmd_code,
  output logic external_wake_pin
);
  initial begin
    dbg_cmd_valid = 1'b0;
    dbg_cmd_code = 3'h7;
    external_wake_pin = 1'b1;
  end

  // Answer stands one cycle, so it is taken at the edge that sees valid
  task automatic send(input logic [2:0] c, output logic acc, output logic err);
    @(posedge pclk);
    dbg_cmd_valid <= 1'b1;
    dbg_cmd_code <= c;
    @(posedge pclk);
    acc = dbg_cmd_accept;
    err = dbg_stop_error;
    dbg_cmd_valid <= 1'b0;
    dbg_cmd_code <= ~c;
  endtask

  // Pin is pulled high except for this one low cycle
  task automatic wake();
    @(posedge pclk);
    external_wake_pin <= 1'b0;
    @(posedge pclk);
    external_wake_pin <= 1'b1;
  endtask
endmodule // debug_host_model

// *** testbench/tb_stop_mode_power_control.sv ***
// Self-checking bench for the stop controller: APB master, debug host, pins.
// Assumes the register map header and the design package are compiled first.
`timescale 1ns/1ps
`include "stop_ctrl_map.svh"
module tb_stop_mode_power_control
  import stop_ctrl_pkg::*;
();
  logic pclk, presetn, psel, penable, pwrite, stop_exec, reset_pin_n, rtc_irq;
  logic [7:0] paddr, wake_irq, port_pin_ctrl, periph_pin_ctrl, periph_pin_en, pin_ctrl_out;
  logic [31:0] pwdata, prdata, pa, pb, pc;
  logic [2:0] dbg_cmd_code;
  logic pready, pslverr, external_wake_pin, dbg_cmd_valid, dbg_cmd_accept, dbg_stop_error;
  logic illegal_opcode_reset, system_reset, fetch_reset_vector, lvd_reset_enable;
  logic lvd_low_trip, active_background, in_stop, debug_clk_en, regulator_full;
  logic periph_clk_en, core_power_off, ram_standby, rtc_on, adc_on, comparator_on;
  logic internal_ref_on, crystal_oscillator_on, usb_on;
  logic [31:0] exp_q[$], msk_q[$];
  int error_cnt, cmp_count, n;
  integer seed;

  stop_mode_power_control #(.PIN_COUNT(8), .IRQ_COUNT(8)) uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .stop_exec, .reset_pin_n, .external_wake_pin, .rtc_irq, .wake_irq, .dbg_cmd_valid,
    .dbg_cmd_code, .dbg_cmd_accept, .dbg_stop_error, .port_pin_ctrl, .periph_pin_ctrl,
    .periph_pin_en, .pin_ctrl_out, .illegal_opcode_reset, .system_reset,
    .fetch_reset_vector, .lvd_reset_enable, .lvd_low_trip, .active_background, .in_stop,
    .debug_clk_en, .regulator_full, .periph_clk_en, .core_power_off, .ram_standby,
    .rtc_on, .adc_on, .comparator_on, .internal_ref_on, .crystal_oscillator_on, .usb_on
  );
  debug_host_model host (.pclk, .dbg_cmd_accept, .dbg_stop_error, .dbg_cmd_valid,
    .dbg_cmd_code, .external_wake_pin);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic test_done();
    if (error_cnt == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask

  // Reads note the masked expectation; the monitor compares at completion
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic se);
    if (!w) begin
      exp_q.push_back(d);
      msk_q.push_back(m);
    end
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : $random(seed);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      test_done();
    end
    chk1(pslverr, se);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
      chk(prdata & msk_q.pop_front(), exp_q.pop_front());
  end

  task automatic stop();
    @(posedge pclk);
    stop_exec <= 1'b1;
    @(posedge pclk);
    stop_exec <= 1'b0;
    #1;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask

  task automatic dbg(input logic [2:0] c, input logic ea, input logic ee);
    logic a, e;
    host.send(c, a, e);
    chk1(a, ea);
    chk1(e, ee);
  endtask

  initial begin
    #100000;
    error_cnt++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h56D932E7;
    {presetn, psel, penable, pwrite, stop_exec, rtc_irq} = 6'h00;
    reset_pin_n = 1'b1;
    {paddr, wake_irq, periph_pin_ctrl, periph_pin_en} = 32'h0;
    pwdata = 32'h0;
    pa = $random(seed);
    port_pin_ctrl = pa[7:0];
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `SPC_CTRL_OFS, 32'h0000000C, 32'hFFFFFFFF, 0);
    apb(0, `SPC_PERIPH_OFS, 32'h0, 32'hFFFFFFFF, 0);
    apb(0, 8'h20, 32'h0, 32'hFFFFFFFF, 1);
    stop();
    chk1(illegal_opcode_reset, 1);
    chk1(in_stop, 0);
    cyc(8);
    apb(1, `SPC_CTRL_OFS, 32'h00000003, 0, 0);
    stop();
    chk1(core_power_off, 1);
    chk1(ram_standby, 1);
    chk1(periph_clk_en, 0);
    @(posedge pclk);
    port_pin_ctrl <= ~pa[7:0];
    cyc(3);
    chk({24'h0, pin_ctrl_out}, pa & 32'hFF);
    host.wake();
    #1;
    chk1(system_reset, 1);
    n = 0;
    while (system_reset === 1'b1 && n < 20) begin
      chk1(fetch_reset_vector, n == 3);
      cyc(1);
      n++;
    end
    chk(n, 4);
    chk1(lvd_reset_enable, 1);
    apb(0, `SPC_STATUS_OFS, 32'h38, 32'h3F, 0);
    apb(0, `SPC_CTRL_OFS, 32'h0000000C, 32'hFFFFFFFF, 0);
    chk({24'h0, pin_ctrl_out}, pa & 32'hFF);
    pb = $random(seed);
    pc = $random(seed);
    @(posedge pclk);
    port_pin_ctrl <= pb[7:0];
    periph_pin_ctrl <= pc[7:0];
    periph_pin_en <= 8'h0F;
    apb(1, `SPC_ACK_OFS, 32'h1, 0, 0);
    apb(0, `SPC_STATUS_OFS, 32'h0, 32'h1F, 0);
    cyc(2);
    chk({24'h0, pin_ctrl_out}, (pc & 32'h0F) | (pb & 32'hF0));
    apb(1, `SPC_CTRL_OFS, 32'h00000013, 0, 0);
    stop();
    chk1(in_stop, 1);
    chk1(core_power_off, 0);
    chk1(debug_clk_en, 1);
    chk1(regulator_full, 1);
    chk1(periph_clk_en, 0);
    dbg(CMD_MEM_STATUS, 0, 1);
    dbg(CMD_NONINTRUSIVE, 0, 0);
    dbg(CMD_GO, 0, 0);
    dbg(CMD_BACKGROUND, 1, 0);
    #1;
    chk1(active_background, 1);
    dbg(CMD_ACTIVE_BG, 1, 0);
    dbg(CMD_GO, 1, 0);
    #1;
    chk1(active_background, 0);
    apb(1, `SPC_PERIPH_OFS, 32'h00001180, 0, 0);
    apb(1, `SPC_CTRL_OFS, 32'h0000000F, 0, 0);
    stop();
    chk1(core_power_off, 0);
    chk1(regulator_full, 1);
    chk1(rtc_on, 1);
    chk1(usb_on, 1);
    chk1(adc_on, 0);
    chk1(internal_ref_on, 0);
    chk1(comparator_on, 1);
    chk1(crystal_oscillator_on, 0);
    @(posedge pclk);
    wake_irq <= 8'h01 << ($random(seed) & 7);
    @(posedge pclk);
    wake_irq <= 8'h00;
    #1;
    chk1(in_stop, 0);
    test_done();
  end
endmodule // tb_stop_mode_power_control
